// ===== src/host_buffer_transfer_control.sv
// Overview of operation
// - Control register cleared by all resets
// - Host-write enable starts host-to-buffer transfer
// - Auto command sets host-write; host resets clear
// - Host-read enable starts buffer-to-host transfer
// - Host-read cleared by host resets or command
// - Direction bit one disk read, zero write
// - Auto command clears direction bit
// - Done flag set on stop equals pointer
// - After done, pointer sits one past stop
// - Daisy-chain command clears done on drive match
// - Done cleared by host resets, reset-register write
// - Auto release bit frees host interrupt on each transfer strobe
// - Upper byte match masked by buffer size
// - Masked match halts transfer, sets done
// - Whole-buffer mode wraps pointers at size top
// - Segmented mode wraps within segment, keeps segment
// - Auto command zeroes write pointer
// - Local reset clears mask, sets auto release
// - Reset-register write clears pointers, stop 01ffh
// - Stop high write restarts enabled transfer
`default_nettype none

module host_buffer_transfer_control
   import host_xfer_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Host side events
   input  wire logic        host_bus_reset_i,
   input  wire logic        host_soft_reset_i,
   input  wire logic        auto_cmd_i,
   input  wire logic        host_cmd_wr_i,
   input  wire logic        drive_select_bit_i,
   input  wire logic        host_xfer_i,
   input  wire logic        host_irq_req_i,
   // Host transfer and buffer outputs
   output logic             host_xfer_req_o,
   output logic             host_irq_n_o,
   output logic [14:0]      buffer_address_low_lines_o,
   output logic             buffer_address_top_line_o
);

   // -------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------
   logic        ack_r;
   logic [31:0] dat_r;
   logic        acc;
   logic        wr;
   logic [7:0]  idx;
   logic [7:0]  wd;
   logic        hit_hi;

   // Writes land at the edge where the master samples ack, so the
   // request must still stand then; a withdrawn request writes nothing.
   assign acc = cyc_i & stb_i & ~ack_r;
   assign wr  = cyc_i & stb_i & ack_r & we_i & sel_i[0];
   assign idx = adr_i[9:2];
   assign wd  = dat_i[7:0];
   assign hit_hi = (adr_i[31:10] == 22'h000000);

   logic wr_ctrl, wr_size, wr_bm, wr_cfg;
   logic wr_rlo, wr_rhi, wr_wlo, wr_whi, wr_slo, wr_shi;

   assign wr_ctrl = wr & hit_hi & (idx == IDX_XFER_CTRL);
   assign wr_size = wr & hit_hi & (idx == IDX_SIZE_MASK);
   assign wr_bm   = wr & hit_hi & (idx == IDX_BM_RESET);
   assign wr_rlo  = wr & hit_hi & (idx == IDX_RD_PTR_LO);
   assign wr_rhi  = wr & hit_hi & (idx == IDX_RD_PTR_HI);
   assign wr_wlo  = wr & hit_hi & (idx == IDX_WR_PTR_LO);
   assign wr_whi  = wr & hit_hi & (idx == IDX_WR_PTR_HI);
   assign wr_slo  = wr & hit_hi & (idx == IDX_STOP_LO);
   assign wr_shi  = wr & hit_hi & (idx == IDX_STOP_HI);
   assign wr_cfg  = wr & hit_hi & (idx == IDX_XFER_CFG);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   logic        host_wr_en_r;
   logic        host_rd_en_r;
   logic        transfer_direction_r;
   logic        done_r;
   logic        halted_r;
   logic [6:0]  size_mask_r;
   logic        auto_irq_r;
   logic        bm_reset_r;
   logic        seg_mode_r;
   logic        ms_en_r;
   logic        ms_sel_r;
   logic        irq_n_r;
   logic [15:0] buffer_read_pointer_r;
   logic [15:0] buffer_write_pointer_r;
   logic [15:0] stop_ptr_r;
   logic [15:0] addr_r;

   logic        host_rst;
   logic        ctrl_clr;
   logic        ptr_clr;
   logic        xfer_go;
   logic        step;
   logic [15:0] act_ptr;
   logic [15:0] low_mask;
   logic [7:0]  hi_mask;
   logic [7:0]  hi_eq;
   logic        match;
   logic        match_hit;
   logic        cmd_clears_done;

   assign host_rst = host_bus_reset_i | host_soft_reset_i;
   // Reset-register bit holds the buffer manager in reset while set
   assign ctrl_clr = rst_i | bm_reset_r | host_rst;
   assign ptr_clr  = rst_i | bm_reset_r | wr_bm;

   // -------------------------------------------------------------------
   // Compare and wrap
   // -------------------------------------------------------------------
   // Mask bit 0 shares its place with the auto release bit, so the
   // lowest upper-byte line always takes part in the compare.
   assign hi_mask  = {size_mask_r, 1'b1};
   assign low_mask = {hi_mask, LOW_BYTE_ONES};
   assign act_ptr  = host_rd_en_r ? buffer_read_pointer_r
                                  : buffer_write_pointer_r;

   // Upper-byte lines take part only where the size mask is one
   for (genvar b = 0; b < 8; b++) begin : g_hi_cmp
      assign hi_eq[b] = (act_ptr[8 + b] == stop_ptr_r[8 + b])
                        | ~hi_mask[b];
   end
   assign match = (act_ptr[7:0] == stop_ptr_r[7:0]) && (&hi_eq);

   assign xfer_go   = (host_wr_en_r | host_rd_en_r) & ~halted_r
                      & ~bm_reset_r;
   assign step      = host_xfer_i & xfer_go;
   assign match_hit = step & match;

   assign cmd_clears_done = host_cmd_wr_i &
                            (~ms_en_r | (drive_select_bit_i == ms_sel_r));

   function automatic logic [15:0] ptr_next(input logic [15:0] p,
                                            input logic [15:0] m,
                                            input logic        seg);
      logic [15:0] inc;
      inc = p + 16'h0001;
      if (seg) begin
         ptr_next = (p & ~m) | (inc & m);
      end else begin
         ptr_next = inc & m;
      end
   endfunction : ptr_next

   // -------------------------------------------------------------------
   // Transfer control register
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (ctrl_clr) begin
         host_wr_en_r <= 1'b0;
      end else if (auto_cmd_i) begin
         host_wr_en_r <= 1'b1;
      end else if (wr_ctrl) begin
         host_wr_en_r <= wd[CTRL_HOST_WR_EN];
      end
   end

   always_ff @(posedge clk_i) begin
      if (ctrl_clr || host_cmd_wr_i) begin
         host_rd_en_r <= 1'b0;
      end else if (wr_ctrl) begin
         host_rd_en_r <= wd[CTRL_HOST_RD_EN];
      end
   end

   always_ff @(posedge clk_i) begin
      if (ctrl_clr || auto_cmd_i) begin
         transfer_direction_r <= 1'b0;
      end else if (wr_ctrl) begin
         transfer_direction_r <= wd[CTRL_DIR];
      end
   end

   // Completion wins over a drive-command clear in the same cycle; resets and reset-register writes win over completion
   always_ff @(posedge clk_i) begin
      if (ctrl_clr || wr_bm) begin
         done_r <= 1'b0;
      end else if (match_hit) begin
         done_r <= 1'b1;
      end else if (cmd_clears_done) begin
         done_r <= 1'b0;
      end
   end

   // Halt is kept apart from done so that a restart leaves done set
   always_ff @(posedge clk_i) begin
      if (ctrl_clr || wr_bm) begin
         halted_r <= 1'b0;
      end else if (match_hit) begin
         halted_r <= 1'b1;
      end else if (wr_shi || wr_ctrl || auto_cmd_i) begin
         halted_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Size, reset and configuration registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         size_mask_r <= SIZE_MASK_RST;
      end else if (wr_size) begin
         size_mask_r <= wd[7:1];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         auto_irq_r <= AUTO_IRQ_RST;
      end else if (wr_size) begin
         auto_irq_r <= wd[SIZE_AUTO_IRQ];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bm_reset_r <= BM_RESET_RST;
      end else if (wr_bm) begin
         bm_reset_r <= wd[BM_RESET_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seg_mode_r <= 1'b0;
      end else if (wr_cfg) begin
         seg_mode_r <= wd[CFG_SEG_MODE];
      end
   end

   // Daisy-chain setup: enable and master or slave choice
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ms_en_r  <= 1'b0;
         ms_sel_r <= 1'b0;
      end else if (wr_cfg) begin
         ms_en_r  <= wd[CFG_MS_EN];
         ms_sel_r <= wd[CFG_MS_SEL];
      end
   end

   // -------------------------------------------------------------------
   // Pointers
   // -------------------------------------------------------------------
   // The byte at the stop address still moves, so a finished pointer
   // ends one past the stop pointer.
   always_ff @(posedge clk_i) begin
      if (ptr_clr) begin
         buffer_read_pointer_r <= PTR_RST;
      end else if (step && host_rd_en_r) begin
         buffer_read_pointer_r <= ptr_next(buffer_read_pointer_r,
                                           low_mask, seg_mode_r);
      end else if (wr_rlo) begin
         buffer_read_pointer_r[7:0] <= wd;
      end else if (wr_rhi) begin
         buffer_read_pointer_r[15:8] <= wd;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ptr_clr || auto_cmd_i) begin
         buffer_write_pointer_r <= PTR_RST;
      end else if (step && !host_rd_en_r) begin
         buffer_write_pointer_r <= ptr_next(buffer_write_pointer_r,
                                            low_mask, seg_mode_r);
      end else if (wr_wlo) begin
         buffer_write_pointer_r[7:0] <= wd;
      end else if (wr_whi) begin
         buffer_write_pointer_r[15:8] <= wd;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ptr_clr || auto_cmd_i) begin
         stop_ptr_r <= STOP_RST;
      end else if (wr_slo) begin
         stop_ptr_r[7:0] <= wd;
      end else if (wr_shi) begin
         stop_ptr_r[15:8] <= wd;
      end
   end

   // Unused high lines are held low in whole-buffer mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_r <= PTR_RST;
      end else if (seg_mode_r) begin
         addr_r <= act_ptr;
      end else begin
         addr_r <= act_ptr & low_mask;
      end
   end

   // -------------------------------------------------------------------
   // Host interrupt
   // -------------------------------------------------------------------
   // A new request wins over the automatic release in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i || host_rst) begin
         irq_n_r <= 1'b1;
      end else if (host_irq_req_i) begin
         irq_n_r <= 1'b0;
      end else if (step && auto_irq_r) begin
         irq_n_r <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Bus answer
   // -------------------------------------------------------------------
   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      if (hit_hi) begin
         case (idx)
            IDX_XFER_CTRL: rd_byte = {2'b00, done_r, transfer_direction_r,
                                      host_rd_en_r, host_wr_en_r, 2'b00};
            IDX_SIZE_MASK: rd_byte = {size_mask_r, auto_irq_r};
            IDX_BM_RESET:  rd_byte = {7'h00, bm_reset_r};
            IDX_RD_PTR_LO: rd_byte = buffer_read_pointer_r[7:0];
            IDX_RD_PTR_HI: rd_byte = buffer_read_pointer_r[15:8];
            IDX_WR_PTR_LO: rd_byte = buffer_write_pointer_r[7:0];
            IDX_WR_PTR_HI: rd_byte = buffer_write_pointer_r[15:8];
            IDX_STOP_LO:   rd_byte = stop_ptr_r[7:0];
            IDX_STOP_HI:   rd_byte = stop_ptr_r[15:8];
            IDX_XFER_CFG:  rd_byte = {~irq_n_r, 4'h0, ms_sel_r, ms_en_r,
                                      seg_mode_r};
            default:       rd_byte = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= acc;
      end
   end

   // Read data is caught at the taking edge and stands until the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= 32'h00000000;
      end else if (acc) begin
         dat_r <= {24'h000000, rd_byte};
      end
   end

   assign ack_o                      = ack_r;
   assign dat_o                      = dat_r;
   assign host_xfer_req_o            = xfer_go;
   assign host_irq_n_o               = irq_n_r;
   assign buffer_address_low_lines_o = addr_r[14:0];
   assign buffer_address_top_line_o  = addr_r[15];

endmodule : host_buffer_transfer_control

`default_nettype wire

// ===== src/host_xfer_pkg.sv
`default_nettype none

package host_xfer_pkg;

   // -------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -------------------------------------------------------------------
   localparam logic [7:0] IDX_XFER_CTRL  = 8'h53;
   localparam logic [7:0] IDX_SIZE_MASK  = 8'h54;
   localparam logic [7:0] IDX_BM_RESET   = 8'h59;
   localparam logic [7:0] IDX_RD_PTR_LO  = 8'h5a;
   localparam logic [7:0] IDX_RD_PTR_HI  = 8'h5b;
   localparam logic [7:0] IDX_WR_PTR_LO  = 8'h5c;
   localparam logic [7:0] IDX_WR_PTR_HI  = 8'h5d;
   localparam logic [7:0] IDX_STOP_LO    = 8'h5e;
   localparam logic [7:0] IDX_STOP_HI    = 8'h5f;
   localparam logic [7:0] IDX_XFER_CFG   = 8'h60;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int CTRL_HOST_WR_EN  = 2;
   localparam int CTRL_HOST_RD_EN  = 3;
   localparam int CTRL_DIR         = 4;
   localparam int CTRL_DONE        = 5;
   localparam int SIZE_AUTO_IRQ    = 0;
   localparam int BM_RESET_BIT     = 0;
   localparam int CFG_SEG_MODE     = 0;
   localparam int CFG_MS_EN        = 1;
   localparam int CFG_MS_SEL       = 2;
   localparam int CFG_IRQ_LEVEL    = 7;

   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [6:0]  SIZE_MASK_RST = 7'h00;
   localparam logic        AUTO_IRQ_RST  = 1'b1;
   localparam logic        BM_RESET_RST  = 1'b1;
   localparam logic [15:0] PTR_RST       = 16'h0000;
   localparam logic [15:0] STOP_RST      = 16'h01ff;
   localparam logic [7:0]  LOW_BYTE_ONES = 8'hff;

endpackage : host_xfer_pkg

`default_nettype wire

// ===== tb/host_side_model.sv
`default_nettype none

module host_side_model (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Request and pacing
   input  wire logic req_i,
   input  wire logic go_i,
   input  wire logic slow_i,
   // One strobe per moved unit
   output var logic  xfer_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Host pacing: every cycle, or one unit in three when slow
   // ----------------------------------------------------------------
   logic [1:0] gap_r;
   always_ff @(posedge clk_i) begin
      if (rst_i || !go_i) begin
         gap_r  <= 2'd0;
         xfer_o <= 1'b0;
      end else begin
         gap_r  <= (gap_r == 2'd2) ? 2'd0 : gap_r + 2'd1;
         xfer_o <= req_i && (!slow_i || gap_r == 2'd2);
      end
   end
endmodule : host_side_model

`default_nettype wire

// ===== tb/host_xfer_chk.sv
`default_nettype none

module host_xfer_chk (
   // Clock, reset and bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // Host side
   input wire logic        host_bus_reset_i,
   input wire logic        host_soft_reset_i,
   input wire logic        auto_cmd_i,
   input wire logic        host_xfer_i,
   input wire logic        host_irq_req_i,
   input wire logic        host_xfer_req_o,
   input wire logic        host_irq_n_o,
   input wire logic [14:0] buffer_address_low_lines_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take; cyc_i && stb_i && !ack_o; endsequence
   sequence s_hrst; host_bus_reset_i || host_soft_reset_i; endsequence
   property p_ack; s_take |=> ack_o ##1 !ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_ack_src; ack_o |-> $past(cyc_i && stb_i); endproperty
   a_ack_src: assert property (p_ack_src) else $error("stray ack");
   property p_dat_hi; ack_o |-> dat_o[31:8] == 24'h0; endproperty
   a_dat_hi: assert property (p_dat_hi) else $error("upper data");
   // Reset must be checked while it is asserted
   property p_rst;
      disable iff (1'b0) rst_i |=> !host_xfer_req_o && host_irq_n_o;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_hrst; s_hrst ##0 !auto_cmd_i && !cyc_i |=> !host_xfer_req_o;
   endproperty
   a_hrst: assert property (p_hrst) else $error("host reset");
   property p_req_src;
      $rose(host_xfer_req_o) |-> $past(cyc_i && we_i) || $past(auto_cmd_i);
   endproperty
   a_req_src: assert property (p_req_src) else $error("req start");
   property p_adv;
      host_xfer_i && host_xfer_req_o && !cyc_i && !auto_cmd_i
         |=> ##1 $changed(buffer_address_low_lines_o);
   endproperty
   a_adv: assert property (p_adv) else $error("no advance");
   property p_irq_set;
      host_irq_req_i && !host_bus_reset_i && !host_soft_reset_i
         |=> !host_irq_n_o;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("irq set");
   property p_irq_hold;
      !host_xfer_i && !$past(host_xfer_i) && !host_irq_req_i && !cyc_i
         && !host_bus_reset_i && !host_soft_reset_i |=> $stable(host_irq_n_o);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq moved");
endmodule : host_xfer_chk

bind host_buffer_transfer_control host_xfer_chk u_chk (.clk_i(clk_i),
   .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o),
   .ack_o(ack_o), .host_bus_reset_i(host_bus_reset_i),
   .host_soft_reset_i(host_soft_reset_i), .auto_cmd_i(auto_cmd_i),
   .host_xfer_i(host_xfer_i), .host_irq_req_i(host_irq_req_i),
   .host_xfer_req_o(host_xfer_req_o), .host_irq_n_o(host_irq_n_o),
   .buffer_address_low_lines_o(buffer_address_low_lines_o));

`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none

module testbench import host_xfer_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Signals, design and host model
   // ----------------------------------------------------------------
   logic        clk_i = 1'b0, rst_i = 1'b1;
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [31:0] adr_i = '0, dat_i = '0, dat_o;
   logic [3:0]  sel_i = 4'h0;
   logic [4:0]  ev = 5'h0;
   logic        ack_o, req_o, irq_n_o, top_o, xfer;
   logic        dsel = 1'b0, go = 1'b0, slow = 1'b0;
   logic [14:0] low_o;
   logic [7:0]  rd;
   int          n_fail = 0, total_checks = 0, cyc_cnt = 0;

`define CHK(nm, e, g) begin \
   total_checks++; \
   if ((g) !== (e)) begin \
      n_fail++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
   end \
end

   host_buffer_transfer_control uut (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .host_bus_reset_i(ev[0]), .host_soft_reset_i(ev[1]),
      .auto_cmd_i(ev[2]), .host_cmd_wr_i(ev[3]),
      .drive_select_bit_i(dsel), .host_xfer_i(xfer),
      .host_irq_req_i(ev[4]), .host_xfer_req_o(req_o),
      .host_irq_n_o(irq_n_o), .buffer_address_low_lines_o(low_o),
      .buffer_address_top_line_o(top_o));
   host_side_model u_host (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_o),
      .go_i(go), .slow_i(slow), .xfer_o(xfer));

   initial forever #5 clk_i = ~clk_i;
   // Ceiling is several times the expected run length
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         n_fail++;
         wrap_up();
      end
   end
   // ----------------------------------------------------------------
   // Bus, event and transfer helpers
   // ----------------------------------------------------------------
   task automatic wb(input logic w, input logic [7:0] idx, d);
      int k;
      k = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      sel_i <= 4'h1;
      adr_i <= {22'h0, idx, 2'b00};
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      if (k == 50) n_fail++;
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic rd_chk(input string nm, input logic [7:0] idx, e);
      wb(1'b0, idx, 8'h00);
      `CHK(nm, e, rd)
   endtask : rd_chk
   task automatic pulse(input logic [4:0] m);
      ev <= m;
      @(posedge clk_i);
      ev <= 5'h0;
      @(posedge clk_i);
   endtask : pulse
   // Hosts keep moving data until the device drops its request
   task automatic run_xfer();
      int k;
      k = 0;
      go <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
      end while (req_o === 1'b1 && k < 100);
      go <= 1'b0;
      @(posedge clk_i);
      `CHK("req", 1'b0, req_o)
   endtask : run_xfer
   task automatic set_ptrs(input logic [7:0] wl, wh, sl, c, sh);
      wb(1'b1, IDX_WR_PTR_LO, wl);
      wb(1'b1, IDX_WR_PTR_HI, wh);
      wb(1'b1, IDX_STOP_LO, sl);
      wb(1'b1, IDX_XFER_CTRL, c);
      wb(1'b1, IDX_STOP_HI, sh);
   endtask : set_ptrs
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_vals();
      rd_chk("ctrl", IDX_XFER_CTRL, 8'h00);
      rd_chk("size", IDX_SIZE_MASK, 8'h01);
      rd_chk("stop_hi", IDX_STOP_HI, 8'h01);
      rd_chk("unmapped", 8'h70, 8'h00);
   endtask : t_reset_vals
   task automatic t_write_xfer();
      wb(1'b1, IDX_BM_RESET, 8'h00);
      wb(1'b1, IDX_SIZE_MASK, 8'hff);
      set_ptrs(8'h00, 8'h00, 8'h02, 8'h04, 8'h00);
      run_xfer();
      rd_chk("ctrl", IDX_XFER_CTRL, 8'h24);
      rd_chk("wptr", IDX_WR_PTR_LO, 8'h03);
      wb(1'b1, IDX_STOP_LO, 8'h05);
      wb(1'b1, IDX_STOP_HI, 8'h00);
      run_xfer();
      rd_chk("wptr", IDX_WR_PTR_LO, 8'h06);
      wb(1'b1, IDX_BM_RESET, 8'h00);
      rd_chk("ctrl", IDX_XFER_CTRL, 8'h04);
      rd_chk("wptr", IDX_WR_PTR_LO, 8'h00);
      rd_chk("stop_lo", IDX_STOP_LO, 8'hff);
      pulse(5'h01);
      rd_chk("ctrl", IDX_XFER_CTRL, 8'h00);
   endtask : t_write_xfer
   task automatic t_read_xfer();
      wb(1'b1, IDX_STOP_LO, 8'h01);
      wb(1'b1, IDX_STOP_HI, 8'h00);
      wb(1'b1, IDX_XFER_CTRL, 8'h18);
      slow <= 1'b1;
      run_xfer();
      slow <= 1'b0;
      rd_chk("rptr", IDX_RD_PTR_LO, 8'h02);
      rd_chk("ctrl", IDX_XFER_CTRL, 8'h38);
      pulse(5'h08);
      rd_chk("ctrl", IDX_XFER_CTRL, 8'h10);
   endtask : t_read_xfer
   task automatic t_auto_cmd();
      wb(1'b1, IDX_WR_PTR_LO, 8'h40);
      pulse(5'h04);
      rd_chk("ctrl", IDX_XFER_CTRL, 8'h04);
      rd_chk("wptr", IDX_WR_PTR_LO, 8'h00);
      pulse(5'h02);
      rd_chk("ctrl", IDX_XFER_CTRL, 8'h00);
   endtask : t_auto_cmd
   // Unit as master first, then as slave
   task automatic t_daisy();
      for (int s = 0; s < 2; s++) begin
         wb(1'b1, IDX_XFER_CFG, (s == 0) ? 8'h02 : 8'h06);
         set_ptrs(8'h00, 8'h00, 8'h00, 8'h04, 8'h00);
         run_xfer();
         dsel <= (s == 0);
         pulse(5'h08);
         rd_chk("ctrl", IDX_XFER_CTRL, 8'h24);
         dsel <= (s != 0);
         pulse(5'h08);
         rd_chk("ctrl", IDX_XFER_CTRL, 8'h04);
      end
   endtask : t_daisy
   task automatic t_wrap();
      logic [15:0] base [2] = '{16'h1ffe, 16'h0ffe};
      logic [15:0] stop [2] = '{16'h1000, 16'h0000};
      for (int i = 0; i < 2; i++) begin
         wb(1'b1, IDX_XFER_CFG, (i == 0) ? 8'h01 : 8'h00);
         wb(1'b1, IDX_SIZE_MASK, (i == 0) ? 8'h0f : 8'h0e);
         pulse(5'h10);
         `CHK("irq", 1'b0, irq_n_o)
         set_ptrs(base[i][7:0], base[i][15:8], stop[i][7:0], 8'h04,
                  stop[i][15:8]);
         run_xfer();
         `CHK("addr", stop[i] + 16'h1, {top_o, low_o})
         `CHK("irq", (i == 0), irq_n_o)
      end
   endtask : t_wrap
   task automatic wrap_up();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset_vals();
      t_write_xfer();
      t_read_xfer();
      t_auto_cmd();
      t_daisy();
      t_wrap();
      wrap_up();
   end
endmodule : testbench

`default_nettype wire
